// File: verilog/hcp_pkg.sv
// Purpose: Constants and types for the hub charge and power config block
// Assumes: Byte-wide configuration registers at their byte offsets
// Notes:   Shared by the top, the OTP store and the charge selector
//
// Summary of operation
// - Two-bit per-port charge enable at offset 06h
// - Automatic charging mode on after reset by default
// - Auto mode picks divider or DCP per device
// - Divider mode advertises 5 W by default
// - High-current bit makes divider advertise 10 W
// - Never CDP while automatic mode enabled
// - Mode from enable, VBUS above 4 V, auto
// - Charge enable also from dual-purpose pin level
// - Register bits enable switching and choose ganging
// - Straps also enable switching and choose ganging
// - Power-enable polarity chosen by config register bit
// - Polarity strap pin also chooses output polarity
// - OTP programmed only through vendor device requests
// - OTP reaches only IDs and listed bits
// - OTP removability bits stored inverted
// - OTP sets auto and high-current bits
// - OTP sets three-bit power-on delay field
// - Upstream without SuperSpeed disables downstream SuperSpeed
// - Full/low-speed upstream also disables downstream high-speed
// - Straps sampled once at reset release
package hcp_pkg;

  localparam int NREG = 9;

  localparam logic [7:0] OFS_VID_LO   = 8'h01;
  localparam logic [7:0] OFS_VID_HI   = 8'h02;
  localparam logic [7:0] OFS_PID_LO   = 8'h03;
  localparam logic [7:0] OFS_PID_HI   = 8'h04;
  localparam logic [7:0] OFS_DEV_CFG  = 8'h05;
  localparam logic [7:0] OFS_CHG_EN   = 8'h06;
  localparam logic [7:0] OFS_RMBL     = 8'h07;
  localparam logic [7:0] OFS_DEV_CFG2 = 8'h0A;
  localparam logic [7:0] OFS_CHG_CTL  = 8'hF2;

  localparam logic [3:0] IDX_DEV_CFG  = 4'h4;
  localparam logic [3:0] IDX_CHG_EN   = 4'h5;
  localparam logic [3:0] IDX_RMBL     = 4'h6;
  localparam logic [3:0] IDX_DEV_CFG2 = 4'h7;
  localparam logic [3:0] IDX_CHG_CTL  = 4'h8;
  localparam logic [3:0] IDX_NONE     = 4'hF;

  // Field positions
  localparam int BIT_GANGED     = 3;
  localparam int BIT_PSW_DIS_N  = 4;
  localparam int BIT_AUTO_DIS_N = 1;
  localparam int BIT_HI_CUR     = 4;
  localparam int BIT_POL        = 5;
  localparam int DLY_LSB        = 1;
  localparam int DLY_MSB        = 3;

  // Reset values, index order; ID bytes come from top parameters
  localparam logic [7:0] REG_RESET [NREG] = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
  // Bits that OTP may reach, and bits stored inverted in OTP
  localparam logic [7:0] OTP_MASK [NREG] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'h00, 8'h00, 8'h03, 8'h12, 8'h0E};
  localparam logic [7:0] OTP_INV [NREG] = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h03, 8'h00, 8'h00};

  typedef enum logic [1:0] {CHG_NONE, CHG_DIVIDER, CHG_DCP, CHG_CDP}
    hcp_chg_e;

  function automatic logic [3:0] hcp_reg_index(input logic [7:0] ofs);
    case (ofs)
      OFS_VID_LO:   hcp_reg_index = 4'h0;
      OFS_VID_HI:   hcp_reg_index = 4'h1;
      OFS_PID_LO:   hcp_reg_index = 4'h2;
      OFS_PID_HI:   hcp_reg_index = 4'h3;
      OFS_DEV_CFG:  hcp_reg_index = IDX_DEV_CFG;
      OFS_CHG_EN:   hcp_reg_index = IDX_CHG_EN;
      OFS_RMBL:     hcp_reg_index = IDX_RMBL;
      OFS_DEV_CFG2: hcp_reg_index = IDX_DEV_CFG2;
      OFS_CHG_CTL:  hcp_reg_index = IDX_CHG_CTL;
      default:      hcp_reg_index = IDX_NONE;
    endcase
  endfunction

endpackage

// File: verilog/hcp_link_if.sv
// Purpose: Internal carrier between top, OTP store and charge selector
// Assumes: One clock domain
// Notes:   Not used at the top-level boundary
`timescale 1ns/10ps
interface hcp_link_if;
  import hcp_pkg::*;
  logic             prog_wr;
  logic [7:0]       prog_ofs;
  logic [7:0]       prog_data;
  logic [7:0]       otp_val  [NREG];
  logic             otp_used [NREG];
  logic [1:0]       chg_en;
  logic [1:0]       dev_divider;
  logic             vbus_hi;
  logic             auto_dis_n;
  hcp_chg_e         mode     [2];

  modport otp_mp  (input prog_wr, prog_ofs, prog_data,
                   output otp_val, otp_used);
  modport chg_mp  (input chg_en, dev_divider, vbus_hi, auto_dis_n,
                   output mode);
endinterface

// File: verilog/hcp_otp.sv
// Purpose: One-time-programmable configuration store
// Assumes: Writes arrive only from the vendor device request decoder
// Notes:   Bits only ever set; otp_por models the blank state at power-on
`timescale 1ns/10ps
module hcp_otp
  import hcp_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  otp_por,
  hcp_link_if.otp_mp lk
);
  logic [7:0] otp_ff  [NREG];
  logic       used_ff [NREG];
  logic [3:0] idx;

  assign idx = hcp_reg_index(lk.prog_ofs);

  // Kept apart from sys_rst so stored values survive a hub reset
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < NREG; i++)
    begin
      if (otp_por)
      begin
        otp_ff[i]  <= 8'h00;
        used_ff[i] <= 1'b0;
      end
      else if (lk.prog_wr && idx == 4'(i) && OTP_MASK[i] != 8'h00)
      begin
        otp_ff[i]  <= otp_ff[i] | (lk.prog_data & OTP_MASK[i]);
        used_ff[i] <= 1'b1;
      end
    end
  end

  for (genvar g = 0; g < NREG; g++)
  begin : g_out
    assign lk.otp_val[g]  = otp_ff[g];
    assign lk.otp_used[g] = used_ff[g];
  end
endmodule // hcp_otp

// File: verilog/hcp_chg.sv
// Purpose: Per-port battery charging mode selection
// Assumes: Inputs already resolved between straps and registers
// Notes:   Purely combinational; the top registers the result
`timescale 1ns/10ps
module hcp_chg
  import hcp_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  sys_rst,
  hcp_link_if.chg_mp lk
);
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    always_comb
    begin
      if (!lk.chg_en[p])
        lk.mode[p] = CHG_NONE;
      else if (!lk.vbus_hi)
      begin
        if (!lk.auto_dis_n)
          lk.mode[p] = lk.dev_divider[p] ? CHG_DIVIDER : CHG_DCP;
        else
          lk.mode[p] = CHG_DCP;
      end
      else
        // Upstream present with auto on: no CDP, plain port
        lk.mode[p] = lk.auto_dis_n ? CHG_CDP : CHG_NONE;
    end

    property p_off_disabled;
      @(posedge sys_clk) disable iff (sys_rst)
      !lk.chg_en[p] |-> lk.mode[p] == CHG_NONE;
    endproperty
    a_off_disabled: assert property (p_off_disabled)
      else $error("charge mode set on a disabled port");
  end
endmodule // hcp_chg

// File: verilog/hcp_top.sv
// Purpose: Hub charging, port power and speed-limit configuration
// Assumes: Config bytes written over the serial config port
// Notes:   Straps and OTP load happen in the first cycle after reset
`timescale 1ns/10ps
module hcp_top
  import hcp_pkg::*;
#(
  // Arbitrary identity defaults
  parameter logic [15:0] VENDOR_ID  = 16'hA5A5,
  parameter logic [15:0] PRODUCT_ID = 16'h5A5A
)
(
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       otp_por,
  input  wire logic       cfg_wr,
  input  wire logic       cfg_rd,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  output wire logic [7:0] cfg_rdata,
  input  wire logic       vreq_otp_wr,
  input  wire logic [7:0] vreq_otp_addr,
  input  wire logic [7:0] vreq_otp_data,
  input  wire logic       power_switching_strap,
  input  wire logic       ganged_strap,
  input  wire logic       power_enable_polarity_strap,
  input  wire logic       bus_mode_strap,
  input  wire logic [1:0] port_power_charge_pin_in,
  output wire logic [1:0] port_power_enable_outputs,
  output wire logic [1:0] port_power_enable_oe,
  input  wire logic [1:0] port_power_req,
  input  wire logic       vbus_above_4v,
  input  wire logic [1:0] device_divider_type,
  input  wire logic       upstream_ss_link,
  input  wire logic       upstream_hs_link,
  output wire hcp_chg_e   port1_charge_mode,
  output wire hcp_chg_e   port2_charge_mode,
  output wire logic       divider_high_current,
  output wire logic       ds_superspeed_enable,
  output wire logic       ds_highspeed_enable,
  output wire logic [2:0] power_on_delay,
  output wire logic [1:0] port_removable,
  output wire logic       bus_mode_slave
);

  hcp_link_if lk();

  logic [7:0] cfg_ff [NREG];
  logic       rst_q_ff;
  logic       release_w;
  logic       psw_strap_ff;
  logic       gang_strap_ff;
  logic       pol_strap_ff;
  logic       bus_strap_ff;
  logic [1:0] chg_strap_ff;
  logic       wr_dev_ff;
  logic       wr_chg_ff;
  logic       wr_cfg2_ff;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic       psw_dis_n_eff;
  logic       ganged_eff;
  logic       pol_eff;
  logic [1:0] chg_en_eff;
  logic [1:0] pwr_on;
  hcp_chg_e   mode_ff [2];
  logic [7:0] rdata_ff;
  logic       div_hi_ff;
  logic       ss_ff;
  logic       hs_ff;
  logic [1:0] pwr_out_ff;
  logic [1:0] pwr_oe_ff;
  logic [2:0] delay_ff;
  logic [1:0] rmbl_ff;

  function automatic logic [7:0] reset_val(input logic [3:0] i);
    case (i)
      4'h0:    reset_val = VENDOR_ID[7:0];
      4'h1:    reset_val = VENDOR_ID[15:8];
      4'h2:    reset_val = PRODUCT_ID[7:0];
      4'h3:    reset_val = PRODUCT_ID[15:8];
      default: reset_val = REG_RESET[i];
    endcase
  endfunction

  assign wr_idx    = hcp_reg_index(cfg_addr);
  assign rd_idx    = hcp_reg_index(cfg_addr);
  assign release_w = rst_q_ff && !sys_rst;

  hcp_otp u_otp (
    .sys_clk (sys_clk),
    .otp_por (otp_por),
    .lk      (lk.otp_mp)
  );

  hcp_chg u_chg (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .lk      (lk.chg_mp)
  );

  assign lk.prog_wr   = vreq_otp_wr;
  assign lk.prog_ofs  = vreq_otp_addr;
  assign lk.prog_data = vreq_otp_data;

  // Reset release detection
  always_ff @(posedge sys_clk)
  begin
    rst_q_ff <= sys_rst;
  end

  // Straps caught once; pins are still inputs here since oe is low
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      psw_strap_ff  <= 1'b1; // Switching off until straps are known
      gang_strap_ff <= 1'b0;
      pol_strap_ff  <= 1'b0;
      bus_strap_ff  <= 1'b0;
      chg_strap_ff  <= 2'b00;
    end
    else if (release_w)
    begin
      psw_strap_ff  <= power_switching_strap;
      gang_strap_ff <= ganged_strap;
      pol_strap_ff  <= power_enable_polarity_strap;
      bus_strap_ff  <= bus_mode_strap;
      chg_strap_ff  <= port_power_charge_pin_in;
    end
  end

  // Configuration bytes: defaults, then OTP, then software writes
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NREG; i++)
        cfg_ff[i] <= reset_val(4'(i));
    end
    else if (release_w)
    begin
      for (int i = 0; i < NREG; i++)
        if (lk.otp_used[i])
          cfg_ff[i] <= (cfg_ff[i] & ~OTP_MASK[i])
                     | ((lk.otp_val[i] ^ OTP_INV[i]) & OTP_MASK[i]);
    end
    else if (cfg_wr && wr_idx != IDX_NONE)
      cfg_ff[wr_idx] <= cfg_wdata;
  end

  // Sticky marks that software has taken a field over from its strap
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wr_dev_ff  <= 1'b0;
      wr_chg_ff  <= 1'b0;
      wr_cfg2_ff <= 1'b0;
    end
    else if (cfg_wr && !release_w)
    begin
      if (wr_idx == IDX_DEV_CFG)
        wr_dev_ff <= 1'b1;
      if (wr_idx == IDX_CHG_EN)
        wr_chg_ff <= 1'b1;
      if (wr_idx == IDX_DEV_CFG2)
        wr_cfg2_ff <= 1'b1;
    end
  end

  // Effective settings: written register, else latched strap
  assign psw_dis_n_eff = wr_dev_ff ? cfg_ff[IDX_DEV_CFG][BIT_PSW_DIS_N]
                                   : psw_strap_ff;
  assign ganged_eff    = wr_dev_ff ? cfg_ff[IDX_DEV_CFG][BIT_GANGED]
                                   : gang_strap_ff;
  assign pol_eff       = wr_cfg2_ff ? cfg_ff[IDX_DEV_CFG2][BIT_POL]
                                    : pol_strap_ff;
  assign chg_en_eff    = wr_chg_ff ? cfg_ff[IDX_CHG_EN][1:0]
                                   : chg_strap_ff;

  assign lk.chg_en      = chg_en_eff;
  assign lk.dev_divider = device_divider_type;
  assign lk.vbus_hi     = vbus_above_4v;
  assign lk.auto_dis_n  = cfg_ff[IDX_DEV_CFG2][BIT_AUTO_DIS_N];

  // Charging outputs
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      mode_ff[0] <= CHG_NONE;
      mode_ff[1] <= CHG_NONE;
      div_hi_ff  <= 1'b0;
    end
    else
    begin
      mode_ff[0] <= lk.mode[0];
      mode_ff[1] <= lk.mode[1];
      div_hi_ff  <= cfg_ff[IDX_DEV_CFG2][BIT_HI_CUR];
    end
  end

  // Ganged ports share one request; per-port follows each request
  assign pwr_on = ganged_eff ? {2{|port_power_req}} : port_power_req;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pwr_oe_ff  <= 2'b00;
      pwr_out_ff <= 2'b00;
    end
    else if (!psw_dis_n_eff)
    begin
      pwr_oe_ff  <= 2'b11;
      pwr_out_ff <= pol_eff ? pwr_on : ~pwr_on;
    end
    else
    begin
      // Pins left as charge-enable inputs when switching is off
      pwr_oe_ff  <= 2'b00;
      pwr_out_ff <= 2'b00;
    end
  end

  // Downstream speed limits follow the upstream link
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ss_ff <= 1'b0;
      hs_ff <= 1'b0;
    end
    else
    begin
      ss_ff <= upstream_ss_link;
      hs_ff <= upstream_ss_link || upstream_hs_link;
    end
  end

  // Register reads and field outputs
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rdata_ff <= 8'h00;
      delay_ff <= 3'h0;
      rmbl_ff  <= 2'b00;
    end
    else
    begin
      if (cfg_rd)
        rdata_ff <= (rd_idx == IDX_NONE) ? 8'h00 : cfg_ff[rd_idx];
      delay_ff <= cfg_ff[IDX_CHG_CTL][DLY_MSB:DLY_LSB];
      rmbl_ff  <= cfg_ff[IDX_RMBL][1:0];
    end
  end

  assign cfg_rdata                 = rdata_ff;
  assign port_power_enable_outputs = pwr_out_ff;
  assign port_power_enable_oe      = pwr_oe_ff;
  assign port1_charge_mode         = mode_ff[0];
  assign port2_charge_mode         = mode_ff[1];
  assign divider_high_current      = div_hi_ff;
  assign ds_superspeed_enable      = ss_ff;
  assign ds_highspeed_enable       = hs_ff;
  assign power_on_delay            = delay_ff;
  assign port_removable            = rmbl_ff;
  assign bus_mode_slave            = bus_strap_ff;

  sequence s_cfg2_write;
    cfg_wr && !release_w && cfg_addr == OFS_DEV_CFG2;
  endsequence

  property p_no_cdp_auto;
    @(posedge sys_clk) disable iff (sys_rst)
    !lk.auto_dis_n |=> mode_ff[0] != CHG_CDP && mode_ff[1] != CHG_CDP;
  endproperty
  a_no_cdp_auto: assert property (p_no_cdp_auto)
    else $error("CDP selected while automatic mode enabled");

  property p_ss_off;
    @(posedge sys_clk) disable iff (sys_rst)
    !upstream_ss_link |=> !ds_superspeed_enable;
  endproperty
  a_ss_off: assert property (p_ss_off)
    else $error("downstream SuperSpeed left on");

  property p_hs_off;
    @(posedge sys_clk) disable iff (sys_rst)
    !upstream_ss_link && !upstream_hs_link
      |=> !ds_highspeed_enable && !ds_superspeed_enable;
  endproperty
  a_hs_off: assert property (p_hs_off)
    else $error("downstream high-speed left on");

  property p_strap_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    !release_w |=> $stable(pol_strap_ff) && $stable(chg_strap_ff);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("strap value changed after reset release");

  property p_write_wins;
    @(posedge sys_clk) disable iff (sys_rst)
    s_cfg2_write ##1 !(cfg_wr && cfg_addr == OFS_DEV_CFG2)
      |-> pol_eff == $past(cfg_wdata[BIT_POL]) && wr_cfg2_ff;
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("written polarity did not override strap");

  property p_otp_mask;
    @(posedge sys_clk) disable iff (sys_rst)
    release_w |=> cfg_ff[IDX_DEV_CFG] == REG_RESET[IDX_DEV_CFG]
               && cfg_ff[IDX_CHG_EN] == REG_RESET[IDX_CHG_EN];
  endproperty
  a_otp_mask: assert property (p_otp_mask)
    else $error("OTP reached a bit outside its map");

  property p_otp_invert;
    @(posedge sys_clk) disable iff (sys_rst)
    release_w && lk.otp_used[IDX_RMBL]
      |=> cfg_ff[IDX_RMBL][1:0] == ~$past(lk.otp_val[IDX_RMBL][1:0]);
  endproperty
  a_otp_invert: assert property (p_otp_invert)
    else $error("removability not inverted on OTP load");

  property p_polarity;
    @(posedge sys_clk) disable iff (sys_rst)
    !psw_dis_n_eff |=> port_power_enable_oe == 2'b11
      && port_power_enable_outputs
         == ($past(pol_eff) ? $past(pwr_on) : ~$past(pwr_on));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("power enable output polarity wrong");

  property p_ganged;
    @(posedge sys_clk) disable iff (sys_rst)
    !psw_dis_n_eff && ganged_eff |=> port_power_enable_outputs[0]
      == port_power_enable_outputs[1];
  endproperty
  a_ganged: assert property (p_ganged)
    else $error("ganged ports driven apart");

  property p_divider;
    @(posedge sys_clk) disable iff (sys_rst)
    !release_w ##1 !release_w
      |-> divider_high_current == $past(cfg_ff[IDX_DEV_CFG2][BIT_HI_CUR]);
  endproperty
  a_divider: assert property (p_divider)
    else $error("divider level does not follow high-current bit");

endmodule // hcp_top

// File: tb/hcp_port_model.sv
// Purpose: Port power switches and attached portable devices
// Assumes: Each dual pin has a strap resistor that sets it while undriven
// Notes:   Device kind per port is chosen by the bench
`timescale 1ns/10ps
module hcp_port_model
(
  input  wire logic [1:0] pe_out,
  input  wire logic [1:0] pe_oe,
  input  wire logic       active_high,
  input  wire logic [1:0] strap_level,
  input  wire logic [1:0] dev_kind,
  output wire logic [1:0] pin_level,
  output wire logic [1:0] port_on,
  output wire logic [1:0] divider_type
);
  // Released pin falls to its resistor, never keeps the driven value
  assign pin_level    = (pe_oe & pe_out) | (~pe_oe & strap_level);
  // Switch closes only when driven at the chosen active level
  assign port_on      = pe_oe & ~(pe_out ^ {2{active_high}});
  assign divider_type = dev_kind;
endmodule // hcp_port_model

// File: tb/testbench.sv
// Purpose: Self-checking bench for the hub charge and power config block
// Assumes: Fixed latencies of the register port, no handshake to wait on
// Notes:   Straps move after reset on purpose; they must not take effect
`timescale 1ns/10ps
module testbench;
  import hcp_pkg::*;
  logic       sys_clk  = 1'b0;
  logic       sys_rst  = 1'b1;
  logic       otp_por  = 1'b1;
  logic       cfg_wr   = 1'b0;
  logic       cfg_rd   = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic       vreq_wr  = 1'b0;
  logic [7:0] vreq_addr = 8'h00;
  logic [7:0] vreq_data = 8'h00;
  logic       psw_strap = 1'b0;
  logic       gang_strap = 1'b1;
  logic       pol_strap = 1'b1;
  logic       bus_strap = 1'b1;
  logic [1:0] pin_strap = 2'b11;
  logic [1:0] dev_kind = 2'b01;
  logic       pol_hi   = 1'b1;
  logic [1:0] pwr_req  = 2'b00;
  logic       vbus_hi  = 1'b0;
  logic       ss_link  = 1'b1;
  logic       hs_link  = 1'b1;
  logic [1:0] pe_out;
  logic [1:0] pe_oe;
  logic [1:0] pin_level;
  logic [1:0] port_on;
  logic [1:0] div_type;
  hcp_chg_e   mode1;
  hcp_chg_e   mode2;
  logic       hi_cur;
  logic       ds_ss;
  logic       ds_hs;
  logic [2:0] pon_dly;
  logic [1:0] rmbl;
  logic       bus_slave;
  int         n_errors = 0;
  int         n_checks = 0;
  logic [7:0] ofs [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h0A, 8'hF2, 8'h08};
  logic [7:0] rst_val [10] = '{8'hE1, 8'hC3, 8'h4D, 8'h2B, 8'h00, 8'h00,
    8'h03, 8'h00, 8'h00, 8'h00};

  always #5 sys_clk = ~sys_clk;

  hcp_top #(.VENDOR_ID(16'hC3E1), .PRODUCT_ID(16'h2B4D)) u_dut
  (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .otp_por(otp_por),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .vreq_otp_wr(vreq_wr), .vreq_otp_addr(vreq_addr),
    .vreq_otp_data(vreq_data), .power_switching_strap(psw_strap),
    .ganged_strap(gang_strap), .power_enable_polarity_strap(pol_strap),
    .bus_mode_strap(bus_strap), .port_power_charge_pin_in(pin_level),
    .port_power_enable_outputs(pe_out), .port_power_enable_oe(pe_oe),
    .port_power_req(pwr_req), .vbus_above_4v(vbus_hi),
    .device_divider_type(div_type), .upstream_ss_link(ss_link),
    .upstream_hs_link(hs_link), .port1_charge_mode(mode1),
    .port2_charge_mode(mode2), .divider_high_current(hi_cur),
    .ds_superspeed_enable(ds_ss), .ds_highspeed_enable(ds_hs),
    .power_on_delay(pon_dly), .port_removable(rmbl),
    .bus_mode_slave(bus_slave)
  );

  hcp_port_model u_sw
  (
    .pe_out(pe_out), .pe_oe(pe_oe), .active_high(pol_hi),
    .strap_level(pin_strap), .dev_kind(dev_kind), .pin_level(pin_level),
    .port_on(port_on), .divider_type(div_type)
  );

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    chk(cfg_rdata, exp);
  endtask

  task automatic otp(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    vreq_wr = 1'b1;
    vreq_addr = a;
    vreq_data = d;
    @(negedge sys_clk);
    vreq_wr = 1'b0;
  endtask

  // Straps settle while reset is high, then outputs get three edges
  task automatic do_reset;
    @(negedge sys_clk);
    sys_rst = 1'b1;
    tick(2);
    otp_por = 1'b0;
    sys_rst = 1'b0;
    tick(3);
  endtask

  initial
  begin
    #200000;
    n_errors++;
    give_verdict();
  end

  initial
  begin
    do_reset();
    for (int i = 0; i < 10; i++)
      rd(ofs[i], rst_val[i]);
    chk(mode1, CHG_DIVIDER);
    chk(mode2, CHG_DCP);
    chk(hi_cur, 1'b0);
    chk(bus_slave, 1'b1);
    pwr_req = 2'b01;
    tick(2);
    chk(pe_oe, 2'b11);
    chk(port_on, 2'b11);
    gang_strap = 1'b0;
    pol_strap = 1'b0;
    pin_strap = 2'b00;
    psw_strap = 1'b1;
    tick(2);
    chk(pe_out, 2'b11);
    chk(mode2, CHG_DCP);
    vbus_hi = 1'b1;
    tick(2);
    chk({mode1, mode2}, {CHG_NONE, CHG_NONE});
    for (int i = 0; i < 4; i++)
    begin
      {ss_link, hs_link} = i[1:0];
      tick(2);
      chk(ds_ss, i[1]);
      chk(ds_hs, i[1] | i[0]);
    end
    wr(OFS_DEV_CFG, 8'h00);
    tick(2);
    chk(pe_out, 2'b01);
    chk(pe_oe, 2'b11);
    wr(OFS_DEV_CFG2, 8'h12);
    pol_hi = 1'b0;
    tick(2);
    chk(pe_out, 2'b10);
    chk(port_on, 2'b01);
    chk({mode1, mode2}, {CHG_CDP, CHG_CDP});
    vbus_hi = 1'b0;
    tick(2);
    chk({mode1, mode2}, {CHG_DCP, CHG_DCP});
    chk(hi_cur, 1'b1);
    wr(OFS_CHG_EN, 8'h01);
    tick(2);
    chk({mode1, mode2}, {CHG_DCP, CHG_NONE});
    wr(OFS_DEV_CFG2, 8'h30);
    pol_hi = 1'b1;
    tick(2);
    chk(mode1, CHG_DIVIDER);
    chk(port_on, 2'b01);
    wr(OFS_DEV_CFG, 8'h10);
    tick(2);
    chk({pe_oe, pe_out}, 4'h0);
    wr(OFS_CHG_CTL, 8'h0E);
    wr(OFS_RMBL, 8'h01);
    tick(2);
    chk(pon_dly, 3'h7);
    chk(rmbl, 2'b01);
    wr(8'h08, 8'h55);
    rd(8'h08, 8'h00);
    otp(OFS_VID_LO, 8'h0F);
    otp(OFS_DEV_CFG2, 8'h12);
    otp(OFS_RMBL, 8'h01);
    otp(OFS_CHG_CTL, 8'hFF);
    otp(OFS_DEV_CFG, 8'hFF);
    pol_hi = 1'b0;
    do_reset();
    rd(OFS_VID_LO, 8'h0F);
    rd(OFS_VID_HI, 8'hC3);
    rd(OFS_DEV_CFG2, 8'h12);
    rd(OFS_RMBL, 8'h02);
    rd(OFS_CHG_CTL, 8'h0E);
    rd(OFS_DEV_CFG, 8'h00);
    chk(hi_cur, 1'b1);
    chk(mode1, CHG_NONE);
    chk(pe_oe, 2'b00);
    wr(OFS_DEV_CFG, 8'h00);
    tick(2);
    chk(pe_out, 2'b10);
    chk(pe_oe, 2'b11);
    @(negedge sys_clk);
    otp_por = 1'b1;
    do_reset();
    rd(OFS_DEV_CFG2, 8'h00);
    rd(OFS_VID_LO, 8'hE1);
    give_verdict();
  end
endmodule // testbench
